// ---- rtl/eqs_defs.svh ----
// constants for the egress queue scheduler
//
// Summary of operation
// - ports 1 and 2 get four ranked queues
// - strict highest queue drains before lower queues
// - strict high queue drains before lower queues
// - strict low queue drains before lowest queue
// - strict lowest queue sends after higher ones
// - ratio mode caps packets per period
// - upper register mode bits 15, 7 reset one
// - lower register mode bits 15, 7 reset one
// - highest ratio in bits 6:0, reset eight
// - high ratio in bits 14:8, reset four
// - lowest ratio in bits 14:8, reset one
// - low ratio in bits 6:0, reset two
// - port 2 copies port 1, runs independently
`ifndef EQS_DEFS_SVH
`define EQS_DEFS_SVH

// register indices; byte address is four times the index
`define EQS_IDX_W 10
`define EQS_IDX_P1_UPPER 10'h0C8
`define EQS_IDX_P1_LOWER 10'h0CA
`define EQS_IDX_P2_UPPER 10'h0CC
`define EQS_IDX_P2_LOWER 10'h0CE
`define EQS_IDX_STATUS 10'h0E0

// bus geometry
`define EQS_ADDR_W 12
`define EQS_ADDR_LSB 2
`define EQS_DATA_W 32
`define EQS_STRB_W 4
`define EQS_BYTE_W 8
`define EQS_REG_W 16

// field layout of a rate control register
`define EQS_MODE_HI 15
`define EQS_MODE_LO 7
`define EQS_RATIO_HI_MSB 14
`define EQS_RATIO_HI_LSB 8
`define EQS_RATIO_LO_MSB 6
`define EQS_RATIO_LO_LSB 0
`define EQS_RATIO_W 7

// reset values
`define EQS_MODE_RST 1'b1
`define EQS_RST_HIGHEST 7'h08
`define EQS_RST_HIGH 7'h04
`define EQS_RST_LOW 7'h02
`define EQS_RST_LOWEST 7'h01
`define EQS_UPPER_RESET \
    {`EQS_MODE_RST, `EQS_RST_HIGH, `EQS_MODE_RST, `EQS_RST_HIGHEST}
`define EQS_LOWER_RESET \
    {`EQS_MODE_RST, `EQS_RST_LOWEST, `EQS_MODE_RST, `EQS_RST_LOW}

// queue ranks and counts
`define EQS_Q_LOWEST 2'h0
`define EQS_Q_LOW 2'h1
`define EQS_Q_HIGH 2'h2
`define EQS_Q_HIGHEST 2'h3
`define EQS_NUM_Q 4
`define EQS_NUM_PORTS 2

// status layout and period default
`define EQS_ST_LAST_LSB 8
`define EQS_PERIOD_DEFAULT 1000

`endif

// ---- rtl/eqs_pkg.sv ----
// types shared by the egress queue scheduler files
`include "eqs_defs.svh"

package eqs_pkg;
    typedef logic [`EQS_RATIO_W-1:0] eqs_ratio_type; // packet allowance
    typedef logic [1:0] eqs_queue_type; // queue rank
    typedef logic [`EQS_REG_W-1:0] eqs_word_type; // register word
    typedef enum logic {
        EQS_GS_IDLE, // may issue a grant
        EQS_GS_HOLD // lets the queue view settle
    } eqs_grant_state_type;
endpackage

// ---- rtl/eqs_sched_if.sv ----
// signals between the register side and one port scheduler
`timescale 1ns/1ps
`include "eqs_defs.svh"

interface eqs_sched_if;
    logic [`EQS_NUM_Q-1:0] pending; // queue holds a packet
    logic tx_ready; // mac can take a packet
    logic [`EQS_NUM_Q-1:0] mode; // 1 ratio, 0 strict
    eqs_pkg::eqs_ratio_type ratio [`EQS_NUM_Q]; // programmed ratio
    logic tick; // period start pulse
    logic grant_valid; // one-cycle grant pulse
    eqs_pkg::eqs_queue_type grant_queue; // last granted queue
    eqs_pkg::eqs_ratio_type allow [`EQS_NUM_Q]; // allowance left

    modport sched (
        input pending, tx_ready, mode, ratio, tick,
        output grant_valid, grant_queue, allow
    );
    modport ctrl (
        output pending, tx_ready, mode, ratio, tick,
        input grant_valid, grant_queue, allow
    );
endinterface

// ---- rtl/eqs_port_sched.sv ----
// per-port queue pick and packet allowance tracking
`timescale 1ns/1ps
`include "eqs_defs.svh"

module eqs_port_sched (
    input wire logic pclk, // core clock
    input wire logic presetn, // async reset, active low
    eqs_sched_if.sched sif // one port's queue view
);

    logic [`EQS_NUM_Q-1:0] elig; // queue may send now
    logic found; // some queue may send
    eqs_pkg::eqs_queue_type pick; // queue chosen this cycle
    logic grant_now; // grant issued at next edge
    eqs_pkg::eqs_grant_state_type state_reg; // pacing state
    eqs_pkg::eqs_grant_state_type state_next; // next pacing state

    genvar q;
    generate
        for (q = 0; q < `EQS_NUM_Q; q++) begin : g_q
            localparam eqs_pkg::eqs_queue_type QID = 2'(q);
            localparam eqs_pkg::eqs_ratio_type ARST =
                (QID == `EQS_Q_HIGHEST) ? `EQS_RST_HIGHEST :
                (QID == `EQS_Q_HIGH) ? `EQS_RST_HIGH :
                (QID == `EQS_Q_LOW) ? `EQS_RST_LOW : `EQS_RST_LOWEST;
            // strict queues always qualify, ratio ones need allowance
            assign elig[q] = sif.pending[q] &&
                (!sif.mode[q] || sif.allow[q] != '0);
            // reload wins over a same-cycle spend; that packet
            // counts against the period just ending
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sif.allow[q] <= ARST;
                end else if (sif.tick) begin
                    sif.allow[q] <= sif.ratio[q];
                end else if (grant_now && pick == QID && sif.mode[q]) begin
                    sif.allow[q] <= sif.allow[q] - 1'b1;
                end
            end
            a_reload_tick:
            assert property (@(posedge pclk) disable iff (!presetn)
                sif.tick |=> sif.allow[q] == $past(sif.ratio[q]))
                else $error("allowance not reloaded at period start");
            a_spent_skip:
            assert property (@(posedge pclk) disable iff (!presetn)
                (sif.mode[q] && sif.allow[q] == '0)
                |=> !(sif.grant_valid && sif.grant_queue == QID))
                else $error("queue with no allowance was granted");
        end
    endgenerate

    // highest eligible queue wins; later loop passes override
    always_comb begin
        found = 1'b0;
        pick = `EQS_Q_LOWEST;
        for (int i = 0; i < `EQS_NUM_Q; i++) begin
            if (elig[i]) begin
                found = 1'b1;
                pick = 2'(i);
            end
        end
    end

    assign grant_now = (state_reg == eqs_pkg::EQS_GS_IDLE) && found
        && sif.tx_ready;

    // one idle cycle after a grant so pending can follow it
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            eqs_pkg::EQS_GS_IDLE: begin
                if (grant_now) begin
                    state_next = eqs_pkg::EQS_GS_HOLD;
                end
            end
            default: begin
                state_next = eqs_pkg::EQS_GS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= eqs_pkg::EQS_GS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // grant pulse and the queue it names, held until next grant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sif.grant_valid <= 1'b0;
            sif.grant_queue <= `EQS_Q_LOWEST;
        end else begin
            sif.grant_valid <= grant_now;
            if (grant_now) begin
                sif.grant_queue <= pick;
            end
        end
    end
endmodule

// ---- rtl/eqs_egress_queue_scheduler.sv ----
// top of the egress queue scheduler: apb registers and two ports
`timescale 1ns/1ps
`include "eqs_defs.svh"

module eqs_egress_queue_scheduler #(
    parameter int PERIOD_CYCLES = `EQS_PERIOD_DEFAULT // period length
) (
    input wire logic pclk, // core clock, 10 MHz
    input wire logic presetn, // async reset, active low
    input wire logic [`EQS_ADDR_W-1:0] paddr, // apb byte address
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [`EQS_DATA_W-1:0] pwdata, // apb write data
    input wire logic [`EQS_STRB_W-1:0] pstrb, // apb byte lanes
    output logic [`EQS_DATA_W-1:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [`EQS_NUM_Q-1:0] p1_queue_pending, // port 1
    input wire logic [`EQS_NUM_Q-1:0] p2_queue_pending, // port 2
    input wire logic p1_mac_tx_ready, // port 1 mac idle
    input wire logic p2_mac_tx_ready, // port 2 mac idle
    output logic p1_grant_valid, // port 1 grant pulse
    output logic [1:0] p1_grant_queue, // port 1 granted queue
    output logic p2_grant_valid, // port 2 grant pulse
    output logic [1:0] p2_grant_queue // port 2 granted queue
);

    // ******************************************************
    // declarations
    // ******************************************************

    localparam int CNT_W = (PERIOD_CYCLES > 1) ?
        $clog2(PERIOD_CYCLES) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PERIOD_CYCLES - 1);

    // rate control registers
    eqs_pkg::eqs_word_type port1_upper_queues_rate_ctrl_reg;
    eqs_pkg::eqs_word_type port1_lower_queues_rate_ctrl_reg;
    eqs_pkg::eqs_word_type port2_upper_queues_rate_ctrl_reg;
    eqs_pkg::eqs_word_type port2_lower_queues_rate_ctrl_reg;

    eqs_pkg::eqs_word_type upper_w [`EQS_NUM_PORTS]; // per port view
    eqs_pkg::eqs_word_type lower_w [`EQS_NUM_PORTS]; // per port view
    logic [`EQS_NUM_Q-1:0] pend_w [`EQS_NUM_PORTS]; // pending view
    logic ready_w [`EQS_NUM_PORTS]; // mac ready view
    eqs_pkg::eqs_word_type status_w; // live status word

    logic [CNT_W-1:0] period_cnt_reg; // cycles into the period
    logic tick_reg; // one pulse per period

    logic [`EQS_IDX_W-1:0] idx; // word index of the access
    logic hit; // index is mapped
    eqs_pkg::eqs_word_type rd_word; // decoded read value
    logic wr_access; // write completes this edge
    logic first_reg; // first cycle after reset release

    logic [`EQS_DATA_W-1:0] prdata_reg; // read data flop
    logic pready_reg; // ready flop
    logic pslverr_reg; // error flop

    eqs_sched_if sif [`EQS_NUM_PORTS] (); // one per network port

    // ******************************************************
    // byte lane merge
    // ******************************************************

    // only lanes 0 and 1 carry register bits; lanes 2, 3 drop
    function automatic eqs_pkg::eqs_word_type merge_lanes(
        input eqs_pkg::eqs_word_type old_val,
        input logic [`EQS_DATA_W-1:0] wdata,
        input logic [`EQS_STRB_W-1:0] strb
    );
        eqs_pkg::eqs_word_type res;
        res = old_val;
        if (strb[0]) begin
            res[`EQS_BYTE_W-1:0] = wdata[`EQS_BYTE_W-1:0];
        end
        if (strb[1]) begin
            res[`EQS_REG_W-1:`EQS_BYTE_W] =
                wdata[`EQS_REG_W-1:`EQS_BYTE_W];
        end
        return res;
    endfunction

    // ******************************************************
    // apb slave
    // ******************************************************

    assign idx = paddr[`EQS_ADDR_W-1:`EQS_ADDR_LSB];
    // pready is only ever high in the access cycle
    assign wr_access = psel && penable && pready_reg && pwrite;

    // address decode; unmapped words read zero and flag an error
    always_comb begin
        rd_word = '0;
        hit = 1'b1;
        if (idx == `EQS_IDX_P1_UPPER) begin
            rd_word = port1_upper_queues_rate_ctrl_reg;
        end else if (idx == `EQS_IDX_P1_LOWER) begin
            rd_word = port1_lower_queues_rate_ctrl_reg;
        end else if (idx == `EQS_IDX_P2_UPPER) begin
            rd_word = port2_upper_queues_rate_ctrl_reg;
        end else if (idx == `EQS_IDX_P2_LOWER) begin
            rd_word = port2_lower_queues_rate_ctrl_reg;
        end else if (idx == `EQS_IDX_STATUS) begin
            rd_word = status_w;
        end else begin
            hit = 1'b0;
        end
    end

    // answer captured in the setup cycle: no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= psel && !penable;
            pslverr_reg <= psel && !penable && !hit;
            prdata_reg <= '0;
            if (psel && !penable && !pwrite) begin
                prdata_reg[`EQS_REG_W-1:0] <= rd_word;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // ******************************************************
    // rate control registers
    // ******************************************************

    // each port owns its own pair; a write touches one word only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port1_upper_queues_rate_ctrl_reg <= `EQS_UPPER_RESET;
            port1_lower_queues_rate_ctrl_reg <= `EQS_LOWER_RESET;
            port2_upper_queues_rate_ctrl_reg <= `EQS_UPPER_RESET;
            port2_lower_queues_rate_ctrl_reg <= `EQS_LOWER_RESET;
        end else if (wr_access) begin
            if (idx == `EQS_IDX_P1_UPPER) begin
                port1_upper_queues_rate_ctrl_reg <= merge_lanes(
                    port1_upper_queues_rate_ctrl_reg, pwdata, pstrb);
            end else if (idx == `EQS_IDX_P1_LOWER) begin
                port1_lower_queues_rate_ctrl_reg <= merge_lanes(
                    port1_lower_queues_rate_ctrl_reg, pwdata, pstrb);
            end else if (idx == `EQS_IDX_P2_UPPER) begin
                port2_upper_queues_rate_ctrl_reg <= merge_lanes(
                    port2_upper_queues_rate_ctrl_reg, pwdata, pstrb);
            end else if (idx == `EQS_IDX_P2_LOWER) begin
                port2_lower_queues_rate_ctrl_reg <= merge_lanes(
                    port2_lower_queues_rate_ctrl_reg, pwdata, pstrb);
            end
            // status word is read only, writes fall through
        end
    end

    // marks the first edge after release for the reset checks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    // ******************************************************
    // scheduling period
    // ******************************************************

    // free-running period; ratio edits apply from the next tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (period_cnt_reg == CNT_LAST);
            if (period_cnt_reg == CNT_LAST) begin
                period_cnt_reg <= '0;
            end else begin
                period_cnt_reg <= period_cnt_reg + 1'b1;
            end
        end
    end

    // ******************************************************
    // port schedulers
    // ******************************************************

    assign upper_w[0] = port1_upper_queues_rate_ctrl_reg;
    assign lower_w[0] = port1_lower_queues_rate_ctrl_reg;
    assign upper_w[1] = port2_upper_queues_rate_ctrl_reg;
    assign lower_w[1] = port2_lower_queues_rate_ctrl_reg;
    assign pend_w[0] = p1_queue_pending;
    assign pend_w[1] = p2_queue_pending;
    assign ready_w[0] = p1_mac_tx_ready;
    assign ready_w[1] = p2_mac_tx_ready;
    // spare status bits read zero rather than float
    assign status_w[`EQS_REG_W-1:`EQS_ST_LAST_LSB + 2*`EQS_NUM_PORTS] = '0;

    genvar p;
    generate
        for (p = 0; p < `EQS_NUM_PORTS; p++) begin : g_port
            logic [`EQS_NUM_Q-1:0] allow_nz; // allowance left
            logic [`EQS_NUM_Q-1:0] view_elig; // checker view

            // field mapping into the four queues of this port
            assign sif[p].mode[`EQS_Q_HIGHEST] =
                upper_w[p][`EQS_MODE_LO];
            assign sif[p].mode[`EQS_Q_HIGH] =
                upper_w[p][`EQS_MODE_HI];
            assign sif[p].mode[`EQS_Q_LOWEST] =
                lower_w[p][`EQS_MODE_HI];
            assign sif[p].mode[`EQS_Q_LOW] =
                lower_w[p][`EQS_MODE_LO];
            assign sif[p].ratio[`EQS_Q_HIGHEST] =
                upper_w[p][`EQS_RATIO_LO_MSB:`EQS_RATIO_LO_LSB];
            assign sif[p].ratio[`EQS_Q_HIGH] =
                upper_w[p][`EQS_RATIO_HI_MSB:`EQS_RATIO_HI_LSB];
            assign sif[p].ratio[`EQS_Q_LOWEST] =
                lower_w[p][`EQS_RATIO_HI_MSB:`EQS_RATIO_HI_LSB];
            assign sif[p].ratio[`EQS_Q_LOW] =
                lower_w[p][`EQS_RATIO_LO_MSB:`EQS_RATIO_LO_LSB];
            assign sif[p].pending = pend_w[p];
            assign sif[p].tx_ready = ready_w[p];
            assign sif[p].tick = tick_reg;

            for (genvar k = 0; k < `EQS_NUM_Q; k++) begin : g_nz
                assign allow_nz[k] = (sif[p].allow[k] != '0);
            end
            assign view_elig = pend_w[p] & (~sif[p].mode | allow_nz);

            // status: allowance flags and last granted queue
            assign status_w[`EQS_NUM_Q*p +: `EQS_NUM_Q] = allow_nz;
            assign status_w[`EQS_ST_LAST_LSB + 2*p +: 2] =
                sif[p].grant_queue;

            // four ranked queues per port, independent instances
            eqs_port_sched u_sched (
                .pclk(pclk),
                .presetn(presetn),
                .sif(sif[p])
            );

            sequence s_grant;
                sif[p].grant_valid;
            endsequence

            a_strict_highest:
            assert property (@(posedge pclk) disable iff (!presetn)
                (s_grant and $past(pend_w[p][`EQS_Q_HIGHEST]
                    && !sif[p].mode[`EQS_Q_HIGHEST]))
                |-> sif[p].grant_queue == `EQS_Q_HIGHEST)
                else $error("strict highest queue was passed over");
            a_strict_high:
            assert property (@(posedge pclk) disable iff (!presetn)
                (s_grant and $past(pend_w[p][`EQS_Q_HIGH]
                    && !sif[p].mode[`EQS_Q_HIGH]))
                |-> sif[p].grant_queue >= `EQS_Q_HIGH)
                else $error("strict high queue was passed over");
            a_strict_low:
            assert property (@(posedge pclk) disable iff (!presetn)
                (s_grant and $past(pend_w[p][`EQS_Q_LOW]
                    && !sif[p].mode[`EQS_Q_LOW]))
                |-> sif[p].grant_queue >= `EQS_Q_LOW)
                else $error("strict low queue lost to lowest");
            a_lowest_last:
            assert property (@(posedge pclk) disable iff (!presetn)
                (s_grant and sif[p].grant_queue == `EQS_Q_LOWEST)
                |-> $past(view_elig[`EQS_NUM_Q-1:1]) == '0)
                else $error("lowest queue sent before higher ones");
            a_grant_gap:
            assert property (@(posedge pclk) disable iff (!presetn)
                s_grant |=> !sif[p].grant_valid)
                else $error("grants issued back to back");
        end
    endgenerate

    assign p1_grant_valid = sif[0].grant_valid;
    assign p1_grant_queue = sif[0].grant_queue;
    assign p2_grant_valid = sif[1].grant_valid;
    assign p2_grant_queue = sif[1].grant_queue;

    // ******************************************************
    // checks
    // ******************************************************

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_write_p1;
        psel && penable && pwrite && idx == `EQS_IDX_P1_UPPER;
    endsequence

    a_apb_ready:
    assert property (@(posedge pclk) disable iff (!presetn)
        s_setup |=> pready ##1 !pready)
        else $error("apb ready not a single access cycle");
    a_unmapped_err:
    assert property (@(posedge pclk) disable iff (!presetn)
        (s_setup and !hit) |=> pslverr && prdata == '0)
        else $error("unmapped access not refused");
    a_reset_upper:
    assert property (@(posedge pclk) disable iff (!presetn)
        first_reg |-> port1_upper_queues_rate_ctrl_reg == `EQS_UPPER_RESET
            && port2_upper_queues_rate_ctrl_reg == `EQS_UPPER_RESET)
        else $error("upper register reset value wrong");
    a_reset_lower:
    assert property (@(posedge pclk) disable iff (!presetn)
        first_reg |-> port1_lower_queues_rate_ctrl_reg == `EQS_LOWER_RESET
            && port2_lower_queues_rate_ctrl_reg == `EQS_LOWER_RESET)
        else $error("lower register reset value wrong");
    a_port_isolated:
    assert property (@(posedge pclk) disable iff (!presetn)
        (s_write_p1 and pready) |=>
            $stable(port2_upper_queues_rate_ctrl_reg)
            && port1_upper_queues_rate_ctrl_reg == $past(merge_lanes(
                port1_upper_queues_rate_ctrl_reg, pwdata, pstrb)))
        else $error("port 1 write missed or leaked to port 2");
    a_period_tick:
    assert property (@(posedge pclk) disable iff (!presetn)
        tick_reg |=> !tick_reg && period_cnt_reg == CNT_W'(1))
        else $error("period tick out of step with counter");
endmodule

// ---- verif/eqs_qm_model.sv ----
// queue manager and mac model facing one egress port
`timescale 1ns/1ps

module eqs_qm_model (
    input wire logic pclk, // core clock
    input wire logic presetn, // async reset, active low
    input wire logic load, // take a new backlog
    input wire logic [31:0] backlog, // packets per queue, one byte each
    input wire logic stall, // mac busy while high
    input wire logic grant_valid, // dequeue pulse
    input wire logic [1:0] grant_queue, // queue to dequeue
    output logic [3:0] pending, // queue non-empty
    output logic tx_ready // mac can take a packet
);
    logic [7:0] cnt_reg [4]; // packets held per queue

    // ****
    // backlog
    // ****
    // a grant on an empty queue wraps the count, so it cannot hide
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '{default: 8'h00};
        end else if (load) begin
            for (int i = 0; i < 4; i++) begin
                cnt_reg[i] <= backlog[i*8 +: 8];
            end
        end else if (grant_valid) begin
            cnt_reg[grant_queue] <= cnt_reg[grant_queue] - 8'h01;
        end
    end

    // pending follows the count by the edge that ends the grant pulse
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pending[i] = (cnt_reg[i] != 8'h00);
        end
    end
    assign tx_ready = !stall;
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the egress queue scheduler
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    bad_count++; $display("BAD %s exp %0h got %0h", n, e, g); end end

module tb_top;
    localparam int PERIOD = 40; // 15 grants fit in one period
    logic pclk = 1'b0, presetn = 1'b0; // clock and reset
    logic [11:0] paddr = '0; // apb address
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb control
    logic [31:0] pwdata = '0, prdata, rd; // apb data
    logic [3:0] pstrb = '0, pend1, pend2; // lanes, queues waiting
    logic pready, pslverr, er, rdy1, rdy2, gv1, gv2; // answers
    logic [1:0] gq1, gq2; // granted queues
    logic ld1 = 1'b0, ld2 = 1'b0, st1 = 1'b0, st2 = 1'b0; // model control
    logic [31:0] bl = '0; // backlog to load
    logic [1:0] log1[$], log2[$]; // grant history per port
    int bad_count = 0, comparisons = 0; // tallies

    eqs_egress_queue_scheduler #(.PERIOD_CYCLES(PERIOD))
        eqs_egress_queue_scheduler_inst (.pclk, .presetn, .paddr, .psel,
        .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .p1_queue_pending(pend1), .p2_queue_pending(pend2),
        .p1_mac_tx_ready(rdy1), .p2_mac_tx_ready(rdy2),
        .p1_grant_valid(gv1), .p1_grant_queue(gq1),
        .p2_grant_valid(gv2), .p2_grant_queue(gq2));
    eqs_qm_model eqs_qm_model_inst (.pclk, .presetn, .load(ld1),
        .backlog(bl), .stall(st1), .grant_valid(gv1), .grant_queue(gq1),
        .pending(pend1), .tx_ready(rdy1));
    eqs_qm_model eqs_qm_model_inst2 (.pclk, .presetn, .load(ld2),
        .backlog(bl), .stall(st2), .grant_valid(gv2), .grant_queue(gq2),
        .pending(pend2), .tx_ready(rdy2));

    // ****
    // clock, grant log, bus master
    // ****
    initial begin
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (gv1 === 1'b1) log1.push_back(gq1);
        if (gv2 === 1'b1) log2.push_back(gq2);
    end

    // one transfer, then an idle edge so psel is never driven twice
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 20) begin
            bad_count++;
            give_verdict();
        end
    endtask

    task automatic check_regs;
        apb(1'b1, 12'h380, 32'h0000_FFFF, 4'h3);
        `CHK("ro write", 1'b0, er)
        apb(1'b0, 12'h380, '0, '0);
        `CHK("status", 32'h0000_00FF, rd)
        for (int p = 0; p < 2; p++) begin
            apb(1'b0, 12'h320 + 12'(p * 16), '0, '0);
            `CHK("upper", 16'h8488, rd[15:0])
            apb(1'b0, 12'h328 + 12'(p * 16), '0, '0);
            `CHK("lower", 16'h8182, rd[15:0])
        end
        apb(1'b0, 12'h004, '0, '0);
        `CHK("unmapped", 1'b1, er)
        apb(1'b1, 12'h320, 32'h0000_0408, 4'h3);
        apb(1'b1, 12'h328, 32'h0000_0002, 4'h1);
        apb(1'b1, 12'h328, 32'h0000_0100, 4'h2);
        apb(1'b0, 12'h328, '0, '0);
        `CHK("lanes", 16'h0102, rd[15:0])
        apb(1'b0, 12'h338, '0, '0);
        `CHK("p2 lower", 16'h8182, rd[15:0])
    endtask

    // all port 1 queues strict, each backlog above its ratio
    task automatic check_strict;
        int k;
        st1 <= 1'b1;
        bl <= 32'h0A06_0302;
        ld1 <= 1'b1;
        @(posedge pclk);
        ld1 <= 1'b0;
        repeat (10) @(posedge pclk);
        `CHK("stalled", 0, log1.size())
        st1 <= 1'b0;
        k = 0;
        while (pend1 !== 4'h0 && k < 200) begin
            @(posedge pclk);
            k++;
        end
        `CHK("drained", 1'b1, k < 200)
        repeat (4) @(posedge pclk);
        `CHK("count", 21, log1.size())
        k = 0;
        for (int q = 3; q >= 0; q--) begin
            for (int j = 0; j < bl[q*8 +: 8]; j++) begin
                `CHK("ord", 2'(q), log1[k])
                k++;
            end
        end
    endtask

    // port 2 at reset ratios: after a lowest grant a full period follows
    task automatic check_ratio;
        int f;
        int k;
        bl <= 32'h3C3C_3C3C;
        ld2 <= 1'b1;
        @(posedge pclk);
        ld2 <= 1'b0;
        k = 0;
        while (log2.size() < 50 && k < 2000) begin
            @(posedge pclk);
            k++;
        end
        `CHK("grants", 1'b1, log2.size() >= 50)
        f = 0;
        while (f < 34 && log2[f] !== 2'h0) f++;
        k = f + 1;
        for (int q = 3; q >= 0; q--) begin
            for (int j = 0; j < (1 << q); j++) begin
                `CHK("ratio", 2'(q), log2[k])
                k++;
            end
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_regs();
        check_strict();
        check_ratio();
        give_verdict();
    end
endmodule
